// ---- common/card_pkg.sv ----
// constants and types shared by the card write path and its bench
package card_pkg;

  localparam int BLOCK_BYTES = 512;
  localparam int NUM_BUFS    = 2;
  localparam int BYTE_BITS   = 8;
  localparam int NIBBLE_BITS = 4;
  localparam int DAT_LINES   = 4;

  typedef enum logic [1:0] {MODE_SPI, MODE_NATIVE1, MODE_NATIVE4} bus_mode_type;
  typedef enum logic [1:0] {L_IDLE, L_RECV, L_DRAIN} link_state_type;
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_SHOW} prog_state_type;

  localparam logic [2:0] BIT_LAST_SERIAL = 3'h7;
  localparam logic [2:0] BIT_LAST_WIDE   = 3'h4;
  localparam logic [2:0] BIT_STEP_SERIAL = 3'h1;
  localparam logic [2:0] BIT_STEP_WIDE   = 3'h4;

endpackage

// ---- common/buf_if.sv ----
// signals between the write path and the block buffer memory
`timescale 1ns/100ps
`default_nettype none
interface buf_if #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 8
);
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;

  modport writer (output wr_en, output wr_addr, output wr_data);
  modport reader (output rd_addr, input rd_data);
  modport mem    (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ---- rtl/card_block_buffer.sv ----
// dual-clock block buffer: written on the card clock, read on the system clock
`timescale 1ns/100ps
`default_nettype none
module card_block_buffer #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 8
)(
  input  wire logic i_wr_clk,
  input  wire logic i_rd_clk,
  buf_if.mem        bus
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rd_q;

  always_ff @(posedge i_wr_clk)
  begin
    if (bus.wr_en)
    begin
      mem[bus.wr_addr] <= bus.wr_data;
    end
  end

  // slot ownership keeps reads and writes on different blocks
  always_ff @(posedge i_rd_clk)
  begin
    rd_q <= mem[bus.rd_addr];
  end

  assign bus.rd_data = rd_q;

endmodule
`default_nettype wire

// ---- rtl/card_write_path.sv ----
// card-side bus pins, block write reception, busy signalling and buffer draining
`timescale 1ns/100ps
`default_nettype none
module card_write_path #(
  parameter int BLOCK_BYTES = card_pkg::BLOCK_BYTES,
  parameter int NUM_BUFS    = card_pkg::NUM_BUFS
)(
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_card_clk,
  input  wire card_pkg::bus_mode_type   i_bus_mode,
  input  wire logic                     i_legacy,
  input  wire logic                     i_init_done,
  input  wire logic                     i_cs_n,
  input  wire logic                     i_host_to_card_line,
  input  wire logic [3:0]               i_dat_in,
  input  wire logic                     i_cmd_in,
  input  wire logic                     i_cmd_bit,
  input  wire logic                     i_cmd_drive,
  input  wire logic                     i_bit_valid,
  input  wire logic                     i_write_start,
  input  wire logic                     i_multi_block,
  input  wire logic                     i_stop,
  input  wire logic                     i_flash_ready,
  output logic                          o_card_to_host_line,
  output logic                          o_card_to_host_oe,
  output logic                          o_cmd_out,
  output logic                          o_cmd_oe,
  output logic [3:0]                    o_dat_out,
  output logic [3:0]                    o_dat_oe,
  output logic                          o_write_active,
  output logic                          o_flash_valid,
  output logic [7:0]                    o_flash_data
);

  localparam int BYTE_W = $clog2(BLOCK_BYTES);
  localparam int SLOT_W = $clog2(NUM_BUFS);
  localparam int FREE_W = $clog2(NUM_BUFS + 1);
  localparam int ADDR_W = SLOT_W + BYTE_W;
  localparam logic [BYTE_W-1:0] LAST_BYTE = BYTE_W'(BLOCK_BYTES - 1);
  localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(NUM_BUFS - 1);
  localparam logic [FREE_W-1:0] ALL_FREE  = FREE_W'(NUM_BUFS);

  typedef struct packed {
    card_pkg::link_state_type state;
    logic                     multi;
    logic                     cs_n;
    logic [7:0]               shift;
    logic [2:0]               bitcnt;
    logic [BYTE_W-1:0]        bytecnt;
    logic [SLOT_W-1:0]        wr_slot;
    logic [FREE_W-1:0]        free_cnt;
    logic                     full_tgl;
    logic [2:0]               free_sync;
    logic                     wr_en;
    logic [ADDR_W-1:0]        wr_addr;
    logic [7:0]               wr_data;
    logic                     cto;
    logic                     cto_oe;
    logic                     cmd_out;
    logic                     cmd_oe;
    logic [3:0]               dat_oe;
  } link_reg_type;

  typedef struct packed {
    card_pkg::prog_state_type state;
    logic [2:0]               full_sync;
    logic [FREE_W-1:0]        pending;
    logic [SLOT_W-1:0]        rd_slot;
    logic [BYTE_W-1:0]        rd_byte;
    logic                     free_tgl;
    logic                     valid;
    logic                     active;
  } sys_reg_type;

  link_reg_type lnk;
  link_reg_type next_lnk;
  sys_reg_type  sys;
  sys_reg_type  next_sys;
  logic         rst_meta;
  logic         lnk_rst_n;
  logic         busy;
  logic         rx_ok;
  logic         byte_done;
  logic         blk_done;
  logic         wide;
  logic         push_pull;
  logic [7:0]   shift_new;

  buf_if #(.ADDR_W(ADDR_W), .DATA_W(8)) bus ();

  card_block_buffer #(.ADDR_W(ADDR_W), .DATA_W(8)) u_buf (
    .i_wr_clk (i_card_clk),
    .i_rd_clk (i_sys_clk),
    .bus      (bus)
  );

  assign bus.wr_en   = lnk.wr_en;
  assign bus.wr_addr = lnk.wr_addr;
  assign bus.wr_data = lnk.wr_data;
  assign bus.rd_addr = {sys.rd_slot, sys.rd_byte};

  // system reset brought onto the card clock
  always_ff @(posedge i_card_clk)
  begin
    rst_meta  <= i_reset_n;
    lnk_rst_n <= rst_meta;
  end

  // card clock domain
  always_comb
  begin
    next_lnk  = lnk;
    wide      = (i_bus_mode == card_pkg::MODE_NATIVE4);
    push_pull = !i_legacy || i_init_done;
    busy      = ((lnk.state == card_pkg::L_RECV) && lnk.multi && (lnk.free_cnt == '0))
             || ((lnk.state == card_pkg::L_DRAIN) && (lnk.free_cnt != ALL_FREE));
    // select gates data at the same edge as the data bit itself
    rx_ok     = (lnk.state == card_pkg::L_RECV) && i_bit_valid && (lnk.free_cnt != '0)
             && ((i_bus_mode != card_pkg::MODE_SPI) || !i_cs_n);
    shift_new = wide ? {lnk.shift[3:0], i_dat_in}
                     : {lnk.shift[6:0], (i_bus_mode == card_pkg::MODE_SPI) ? i_host_to_card_line
                                                                           : i_dat_in[0]};
    byte_done = rx_ok && (lnk.bitcnt == (wide ? card_pkg::BIT_LAST_WIDE
                                              : card_pkg::BIT_LAST_SERIAL));
    blk_done  = byte_done && (lnk.bytecnt == LAST_BYTE);

    next_lnk.cs_n         = i_cs_n;
    next_lnk.free_sync    = {lnk.free_sync[1:0], sys.free_tgl};
    next_lnk.wr_en        = byte_done;
    next_lnk.wr_data      = shift_new;
    next_lnk.wr_addr      = {lnk.wr_slot, lnk.bytecnt};
    if (rx_ok)
    begin
      next_lnk.shift  = shift_new;
      next_lnk.bitcnt = lnk.bitcnt + (wide ? card_pkg::BIT_STEP_WIDE : card_pkg::BIT_STEP_SERIAL);
    end
    if (byte_done)
    begin
      next_lnk.bytecnt = lnk.bytecnt + 1'b1;
    end
    // a filled slot and a freed slot in one cycle cancel out
    next_lnk.free_cnt = lnk.free_cnt - FREE_W'(blk_done)
                      + FREE_W'(lnk.free_sync[2] ^ lnk.free_sync[1]);
    if (blk_done)
    begin
      next_lnk.full_tgl = !lnk.full_tgl;
      next_lnk.wr_slot  = (lnk.wr_slot == LAST_SLOT) ? '0 : lnk.wr_slot + 1'b1;
    end

    case (lnk.state)
      card_pkg::L_IDLE:
      begin
        if (i_write_start)
        begin
          next_lnk.state   = card_pkg::L_RECV;
          next_lnk.multi   = i_multi_block;
          next_lnk.bitcnt  = '0;
          next_lnk.bytecnt = '0;
        end
      end
      card_pkg::L_RECV:
      begin
        if ((blk_done && !lnk.multi) || (lnk.multi && i_stop))
        begin
          next_lnk.state = card_pkg::L_DRAIN;
        end
      end
      card_pkg::L_DRAIN:
      begin
        if (lnk.free_cnt == ALL_FREE)
        begin
          next_lnk.state = card_pkg::L_IDLE;
        end
      end
      default:
      begin
        next_lnk.state = card_pkg::L_IDLE;
      end
    endcase

    // the card-to-host enable works from the registered select, hence two clocks of lag
    next_lnk.cto    = !busy;
    next_lnk.cto_oe = (i_bus_mode == card_pkg::MODE_SPI) && !lnk.cs_n;
    next_lnk.dat_oe = {3'h0, (i_bus_mode != card_pkg::MODE_SPI) && busy};
    next_lnk.cmd_out = i_cmd_bit;
    // before push-pull the command line only ever pulls low
    next_lnk.cmd_oe  = (i_bus_mode != card_pkg::MODE_SPI) && i_cmd_drive
                    && (push_pull || !i_cmd_bit);
  end

  always_ff @(posedge i_card_clk)
  begin
    if (!lnk_rst_n)
    begin
      lnk          <= '0;
      lnk.free_cnt <= ALL_FREE;
    end
    else
    begin
      lnk <= next_lnk;
    end
  end

  // system clock domain: hands each full slot to the flash side in byte order
  always_comb
  begin
    next_sys           = sys;
    next_sys.full_sync = {sys.full_sync[1:0], lnk.full_tgl};
    next_sys.pending   = sys.pending + FREE_W'(sys.full_sync[2] ^ sys.full_sync[1]);
    next_sys.active    = (sys.pending != '0);
    case (sys.state)
      card_pkg::S_IDLE:
      begin
        if (sys.pending != '0)
        begin
          next_sys.state = card_pkg::S_WAIT;
        end
      end
      card_pkg::S_WAIT:
      begin
        next_sys.state = card_pkg::S_SHOW;
        next_sys.valid = 1'b1;
      end
      card_pkg::S_SHOW:
      begin
        if (i_flash_ready)
        begin
          next_sys.valid   = 1'b0;
          next_sys.rd_byte = sys.rd_byte + 1'b1;
          next_sys.state   = card_pkg::S_WAIT;
          if (sys.rd_byte == LAST_BYTE)
          begin
            next_sys.state    = card_pkg::S_IDLE;
            next_sys.free_tgl = !sys.free_tgl;
            next_sys.rd_slot  = (sys.rd_slot == LAST_SLOT) ? '0 : sys.rd_slot + 1'b1;
            next_sys.pending  = sys.pending - 1'b1
                              + FREE_W'(sys.full_sync[2] ^ sys.full_sync[1]);
          end
        end
      end
      default:
      begin
        next_sys.state = card_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      sys <= '0;
    end
    else
    begin
      sys <= next_sys;
    end
  end

  assign o_card_to_host_line = lnk.cto;
  assign o_card_to_host_oe   = lnk.cto_oe;
  assign o_cmd_out           = lnk.cmd_out;
  assign o_cmd_oe            = lnk.cmd_oe;
  assign o_dat_out           = 4'h0;
  assign o_dat_oe            = lnk.dat_oe;
  assign o_write_active      = sys.active;
  assign o_flash_valid       = sys.valid;
  assign o_flash_data        = bus.rd_data;

  sequence s_spi_deselect;
    (i_bus_mode == card_pkg::MODE_SPI) && i_cs_n;
  endsequence

  sequence s_single_fill;
    (lnk.state == card_pkg::L_RECV) && !lnk.multi && blk_done;
  endsequence

  chk_cs_release: assert property (@(posedge i_card_clk) disable iff (!lnk_rst_n)
    s_spi_deselect |-> ##2 !o_card_to_host_oe)
    else $error("output line still driven after deselect");

  chk_busy_resume: assert property (@(posedge i_card_clk) disable iff (!lnk_rst_n)
    ((i_bus_mode == card_pkg::MODE_SPI) && !lnk.cs_n && busy)
      |=> (o_card_to_host_oe && !o_card_to_host_line))
    else $error("busy not driven low while selected");

  chk_single_busy: assert property (@(posedge i_card_clk) disable iff (!lnk_rst_n)
    s_single_fill ##1 (lnk.free_cnt != ALL_FREE) |-> (lnk.state == card_pkg::L_DRAIN) && busy)
    else $error("single block write not busy after fill");

  chk_multi_free: assert property (@(posedge i_card_clk) disable iff (!lnk_rst_n)
    ((lnk.state == card_pkg::L_RECV) && lnk.multi && (lnk.free_cnt != '0)
      && (i_bus_mode != card_pkg::MODE_SPI)) |=> !o_dat_oe[0])
    else $error("busy shown with a free buffer");

  chk_one_block: assert property (@(posedge i_card_clk) disable iff (!lnk_rst_n)
    (lnk.state != card_pkg::L_RECV) |=> !lnk.wr_en)
    else $error("data stored outside a write");

  chk_stop_multi: assert property (@(posedge i_card_clk) disable iff (!lnk_rst_n)
    ((lnk.state == card_pkg::L_RECV) && lnk.multi && i_stop) |=> (lnk.state == card_pkg::L_DRAIN))
    else $error("stop did not end a multi block write");

  chk_open_drain: assert property (@(posedge i_card_clk) disable iff (!lnk_rst_n)
    (i_legacy && !i_init_done && i_cmd_drive && i_cmd_bit) |=> !o_cmd_oe)
    else $error("command line driven high before push-pull");

  chk_push_pull: assert property (@(posedge i_card_clk) disable iff (!lnk_rst_n)
    ((!i_legacy || i_init_done) && i_cmd_drive && (i_bus_mode != card_pkg::MODE_SPI))
      |=> (o_cmd_oe && (o_cmd_out == $past(i_cmd_bit))))
    else $error("command line not driven push-pull");

  chk_serial_lines: assert property (@(posedge i_card_clk) disable iff (!lnk_rst_n)
    (i_bus_mode == card_pkg::MODE_SPI) |=> (o_dat_oe == 4'h0) && !o_cmd_oe)
    else $error("shared lines driven in serial mode");

  chk_select_gate: assert property (@(posedge i_card_clk) disable iff (!lnk_rst_n)
    ((i_bus_mode == card_pkg::MODE_SPI) && i_cs_n) |=> $stable(lnk.shift))
    else $error("data taken while deselected");

  chk_flash_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (o_flash_valid && !i_flash_ready) |=> (o_flash_valid && $stable(o_flash_data)))
    else $error("flash byte dropped before accept");

endmodule
`default_nettype wire

// ---- bench/card_host_model.sv ----
// host-side model driving the card pins on the card clock
`timescale 1ns/100ps
`default_nettype none
module card_host_model (
  input  wire logic  i_card_clk,
  input  wire logic  i_busy,
  output logic       o_cs_n,
  output logic       o_line,
  output logic [3:0] o_dat,
  output logic       o_valid,
  output logic       o_start,
  output logic       o_multi,
  output logic       o_stop
);
  initial
    {o_cs_n, o_line, o_dat, o_valid, o_start, o_multi, o_stop} = 10'h300;

  task automatic start(input logic multi);
    @(posedge i_card_clk);
    o_start <= 1'h1;
    o_multi <= multi;
    @(posedge i_card_clk);
    o_start <= 1'h0;
  endtask

  task automatic stop();
    @(posedge i_card_clk);
    o_stop <= 1'h1;
    @(posedge i_card_clk);
    o_stop <= 1'h0;
  endtask

  task automatic set_cs(input logic sel_n);
    @(posedge i_card_clk);
    o_cs_n <= sel_n;
  endtask

  // serial sends msb first, wide sends the high nibble first
  task automatic send_byte(input logic [7:0] b, input logic wide, input logic sel_n);
    int i;
    while (i_busy)
      @(posedge i_card_clk);
    o_cs_n <= sel_n;
    for (i = 0; i < (wide ? 2 : 8); i++)
    begin
      o_valid <= 1'h1;
      o_line  <= b[7-i];
      o_dat   <= wide ? (i == 0 ? b[7:4] : b[3:0]) : {3'h0, b[7-i]};
      @(posedge i_card_clk);
    end
    // released lines show the inverse so a stale bit cannot pass
    o_valid <= 1'h0;
    o_line  <= ~o_line;
    o_dat   <= ~o_dat;
    // one idle edge, so the next byte never reassigns a line in this time step
    @(posedge i_card_clk);
  endtask
endmodule
`default_nettype wire

// ---- bench/card_write_path_bench.sv ----
// bench for the card write path: host model, flash sink and scenarios
`timescale 1ns/100ps
`default_nettype none
module card_write_path_bench;
  localparam int BYTES = 4;
  // host write timeout from the card's access, clocked access and speed factor fields
  localparam int ACCESS_TIME_FIELD_NS = 1000;
  localparam int CLOCKED_ACCESS_FIELD = 1;
  localparam int WRITE_SPEED_FACTOR   = 4;
  localparam int CARD_PERIOD_NS       = 125;
  localparam int CLOCKED_ACCESS_NS    = CLOCKED_ACCESS_FIELD * 100 * CARD_PERIOD_NS;
  localparam int LEGACY_WRITE_NS      = 10 * WRITE_SPEED_FACTOR
                                      * (ACCESS_TIME_FIELD_NS + CLOCKED_ACCESS_NS);
  localparam int SECURE_WRITE_NS      = 250000000;
  realtime                card_half = 62.5;
  logic                   i_sys_clk = 1'h0;
  logic                   i_card_clk = 1'h0;
  logic                   i_reset_n = 1'h0;
  card_pkg::bus_mode_type i_bus_mode = card_pkg::MODE_SPI;
  logic                   i_legacy = 1'h0;
  logic                   i_init_done = 1'h0;
  logic                   i_cmd_bit = 1'h0;
  logic                   i_cmd_drive = 1'h0;
  logic                   i_flash_ready = 1'h0;
  logic                   hold_flash = 1'h1;
  logic                   i_cs_n, i_host_to_card_line, i_bit_valid, i_cmd_in, busy;
  logic                   i_write_start, i_multi_block, i_stop;
  logic [3:0]             i_dat_in, o_dat_out, o_dat_oe;
  logic                   o_card_to_host_line, o_card_to_host_oe, o_cmd_out, o_cmd_oe;
  logic                   o_write_active, o_flash_valid;
  logic [7:0]             o_flash_data;
  logic [7:0]             got_q[$];
  int                     fails = 0;
  int                     checks = 0;

  always #25 i_sys_clk = ~i_sys_clk;
  // the slow half period keeps a legacy card in open-drain at 400 kHz
  always #(card_half) i_card_clk = ~i_card_clk;

  assign i_cmd_in = o_cmd_oe ? o_cmd_out : 1'h1;
  assign busy = (i_bus_mode == card_pkg::MODE_SPI) ? (o_card_to_host_oe && !o_card_to_host_line)
                                                   : (o_dat_oe[0] && !o_dat_out[0]);

  // flash sink stalls every other cycle even when released
  always @(posedge i_sys_clk)
  begin
    i_flash_ready <= !hold_flash && !i_flash_ready;
    if (o_flash_valid && i_flash_ready)
      got_q.push_back(o_flash_data);
  end

  card_write_path #(.BLOCK_BYTES(BYTES)) DUT (
    .i_sys_clk, .i_reset_n, .i_card_clk, .i_bus_mode, .i_legacy, .i_init_done,
    .i_cs_n, .i_host_to_card_line, .i_dat_in, .i_cmd_in, .i_cmd_bit, .i_cmd_drive,
    .i_bit_valid, .i_write_start, .i_multi_block, .i_stop, .i_flash_ready,
    .o_card_to_host_line, .o_card_to_host_oe, .o_cmd_out, .o_cmd_oe, .o_dat_out,
    .o_dat_oe, .o_write_active, .o_flash_valid, .o_flash_data
  );

  card_host_model host (
    .i_card_clk(i_card_clk), .i_busy(busy), .o_cs_n(i_cs_n), .o_line(i_host_to_card_line),
    .o_dat(i_dat_in), .o_valid(i_bit_valid), .o_start(i_write_start),
    .o_multi(i_multi_block), .o_stop(i_stop)
  );

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_card(input int n);
    repeat (n) @(posedge i_card_clk);
    #1;
  endtask

  task automatic send(input logic [7:0] base, input logic wide, input logic sel_n);
    int i;
    for (i = 0; i < BYTES; i++)
      host.send_byte(8'(base + i), wide, sel_n);
    wait_card(4);
  endtask

  // release the flash side, wait for all blocks, compare what arrived
  task automatic drain(input logic [7:0] base, input int n);
    int k;
    int limit_ns;
    limit_ns = i_legacy ? LEGACY_WRITE_NS : SECURE_WRITE_NS;
    check_bit(o_write_active, 1'h1, "blocks pending");
    hold_flash = 1'h0;
    // poll busy in 50 ns steps up to the derived legacy timeout or the fixed secure one
    for (k = 0; k * 50 < limit_ns && (o_write_active !== 1'h0 || busy !== 1'h0); k++)
      #50;
    check_bit(busy, 1'h0, "busy released");
    check_bit(o_write_active, 1'h0, "flash side idle");
    check_byte(8'(got_q.size()), 8'(n), "byte count");
    for (k = 0; k < n && k < got_q.size(); k++)
      check_byte(got_q[k], 8'(base + k), "flash data");
    got_q = {};
    hold_flash = 1'h1;
  endtask

  task automatic s_cmd();
    card_half = 1250.0;
    i_bus_mode <= card_pkg::MODE_NATIVE1;
    i_legacy <= 1'h1;
    i_cmd_drive <= 1'h1;
    i_cmd_bit <= 1'h1;
    wait_card(3);
    check_bit(o_cmd_oe, 1'h0, "open drain high");
    i_cmd_bit <= 1'h0;
    wait_card(3);
    check_bit(o_cmd_oe && !o_cmd_out, 1'h1, "open drain low");
    i_init_done <= 1'h1;
    i_cmd_bit <= 1'h1;
    card_half = 62.5;
    wait_card(3);
    check_bit(o_cmd_oe && o_cmd_out, 1'h1, "push pull high");
    i_cmd_drive <= 1'h0;
    wait_card(3);
    check_bit(o_cmd_oe, 1'h0, "command released");
  endtask

  task automatic s_serial();
    i_bus_mode <= card_pkg::MODE_SPI;
    host.start(1'h0);
    host.send_byte(8'hFF, 1'h0, 1'h1);
    send(8'h30, 1'h0, 1'h0);
    check_bit(busy, 1'h1, "single busy");
    host.set_cs(1'h1);
    wait_card(3);
    check_bit(o_card_to_host_oe, 1'h0, "deselect release");
    host.set_cs(1'h0);
    wait_card(3);
    check_bit(busy, 1'h1, "reselect busy");
    drain(8'h30, BYTES);
  endtask

  task automatic s_wide();
    i_bus_mode <= card_pkg::MODE_NATIVE4;
    // wide mode exists on the secure card type only
    i_legacy <= 1'h0;
    host.start(1'h0);
    send(8'hC0, 1'h1, 1'h1);
    check_bit(busy, 1'h1, "wide busy");
    check_byte({4'h0, o_dat_oe}, 8'h01, "busy line only");
    drain(8'hC0, BYTES);
  endtask

  task automatic s_multi();
    i_bus_mode <= card_pkg::MODE_NATIVE1;
    i_legacy <= 1'h1;
    host.start(1'h1);
    send(8'h50, 1'h0, 1'h1);
    check_bit(busy, 1'h0, "free buffer left");
    send(8'h54, 1'h0, 1'h1);
    check_bit(busy, 1'h1, "all buffers full");
    host.stop();
    drain(8'h50, 2 * BYTES);
  endtask

  initial
  begin
    repeat (19) @(posedge i_sys_clk);
    #1;
    check_byte({o_write_active, o_flash_valid, o_cmd_oe, o_card_to_host_oe, o_dat_oe},
               8'h00, "reset outputs");
    @(posedge i_sys_clk);
    i_reset_n <= 1'h1;
    wait_card(4);
    s_cmd();
    s_serial();
    s_wide();
    s_multi();
    end_sim();
  end

  initial
  begin
    #1000000;
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
